// *** hw/rtstc_pkg.sv ***
// Constants, register map and field layout of the run and shutdown control block.
package rtstc_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int INT_W  = 2;

  localparam logic [ADDR_W-1:0] OFF_CONFIG_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONFIG_TWO = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_BIT_WORD   = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_INT_PEND   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK   = 4'h5;

  localparam int SCOPE_BIT       = 12;
  localparam int TTSEL_LSB       = 9;
  localparam int RUN_BIT         = 8;
  localparam int AUTO_SD_DIS_BIT = 4;
  localparam int STAT_APF_BIT    = 0;
  localparam int STAT_RUN_BIT    = 1;
  localparam int BITW_TX_LSB     = 0;
  localparam int BITW_RX_LSB     = 2;
  localparam int INT_APF         = 0;
  localparam int INT_SHUTDOWN    = 1;

  localparam logic        SCOPE_RESET       = 1'b0;
  localparam logic [2:0]  TTSEL_RESET       = 3'h0;
  localparam logic        RUN_RESET         = 1'b0;
  localparam logic        AUTO_SD_DIS_RESET = 1'b0;
  localparam logic [INT_W-1:0] MASK_RESET   = 2'h0;

  localparam logic [2:0] TT_OFF = 3'h0;
  localparam logic [2:0] TT_EXT = 3'h1;
  localparam logic [2:0] TT_2US = 3'h2;
  localparam logic [2:0] TT_4US = 3'h3;

  localparam int CLK_PERIOD_NS     = 100;
  localparam int TT_BASE_PERIOD_NS = 2000;
  localparam logic [4:0] TT_BASE_CYCLES = 5'(TT_BASE_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [4:0] TT_BASE_LAST   = TT_BASE_CYCLES - 5'h1;
endpackage

// *** hw/rtstc_irq_if.sv ***
// Interface between the control logic and its interrupt status block.
interface rtstc_irq_if import rtstc_pkg::*; ();
  logic [INT_W-1:0] event_set;
  logic [INT_W-1:0] clear_ones;
  logic [INT_W-1:0] mask_wdata;
  logic             mask_we;
  logic [INT_W-1:0] pending;
  logic [INT_W-1:0] mask;
  logic             irq;
  modport ctrl (output event_set, clear_ones, mask_wdata, mask_we,
                input pending, mask, irq);
  modport flags (input event_set, clear_ones, mask_wdata, mask_we,
                 output pending, mask, irq);
endinterface

// *** hw/rtstc_irq.sv ***
// Sticky interrupt status with write-one-to-clear, mask and level output.
module rtstc_irq import rtstc_pkg::*; (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  rtstc_irq_if.flags  irq_b
);
  typedef struct packed {
    logic [INT_W-1:0] pending;
    logic [INT_W-1:0] mask;
    logic             irq;
  } rtstc_irq_state_t;

  rtstc_irq_state_t s_reg;
  rtstc_irq_state_t s_next;

  always_comb begin
    s_next = s_reg;
    // A new event outranks a clear written in the same cycle.
    s_next.pending = (s_reg.pending & ~irq_b.clear_ones) | irq_b.event_set;
    if (irq_b.mask_we) begin
      s_next.mask = irq_b.mask_wdata;
    end
    s_next.irq = |(s_next.pending & s_next.mask);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '{pending: '0, mask: MASK_RESET, irq: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign irq_b.pending = s_reg.pending;
  assign irq_b.mask    = s_reg.mask;
  assign irq_b.irq     = s_reg.irq;

  property p_event_sticks;
    @(posedge clk_i) disable iff (reset_i)
      irq_b.event_set[INT_APF] |=> irq_b.pending[INT_APF]
        ##1 (irq_b.pending[INT_APF] || $past(irq_b.clear_ones[INT_APF]));
  endproperty
  a_event_sticks: assert property (p_event_sticks) else $error("apf pending lost");
endmodule

// *** hw/rtstc_tick_gen.sv ***
// Time-tag counter clock enable from the external pin or an internal divider.
module rtstc_tick_gen import rtstc_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       ext_clk_i,
  output logic            tick_o
);
  typedef struct packed {
    logic [4:0] base_cnt;
    logic [4:0] prescale;
    logic       ext_prev;
    logic       tick;
  } rtstc_tick_state_t;

  rtstc_tick_state_t s_reg;
  rtstc_tick_state_t s_next;
  logic              base_tick;
  logic [4:0]        pmask;

  always_comb begin
    s_next          = s_reg;
    s_next.ext_prev = ext_clk_i;
    base_tick       = (s_reg.base_cnt == TT_BASE_LAST);
    // Codes 2..7 divide the 2 us base by 1, 2, 4, 8, 16 and 32.
    pmask           = 5'((6'h1 << (sel_i - TT_2US)) - 6'h1);
    s_next.tick     = 1'b0;
    if (sel_i == TT_OFF) begin
      s_next.base_cnt = 5'h0;
      s_next.prescale = 5'h0;
    end else begin
      s_next.base_cnt = base_tick ? 5'h0 : s_reg.base_cnt + 5'h1;
      if (base_tick) begin
        s_next.prescale = s_reg.prescale + 5'h1;
      end
      case (sel_i)
        TT_EXT: s_next.tick = ext_clk_i & ~s_reg.ext_prev;
        default: s_next.tick = base_tick && ((s_reg.prescale & pmask) == 5'h0);
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;

  property p_tt_off;
    @(posedge clk_i) disable iff (reset_i) (sel_i == TT_OFF) |=> !tick_o;
  endproperty
  a_tt_off: assert property (p_tt_off) else $error("tick while disabled");
  property p_tt_ext;
    @(posedge clk_i) disable iff (reset_i)
      (sel_i == TT_EXT && ext_clk_i && !$past(ext_clk_i)) |=> tick_o;
  endproperty
  a_tt_ext: assert property (p_tt_ext) else $error("external edge missed");
  property p_tt_2us;
    @(posedge clk_i) disable iff (reset_i)
      (tick_o && sel_i == TT_2US) |-> ##20 (tick_o || sel_i != TT_2US);
  endproperty
  a_tt_2us: assert property (p_tt_2us) else $error("2 us period wrong");
  property p_tt_4us;
    @(posedge clk_i) disable iff (reset_i)
      (tick_o && sel_i == TT_4US)
        |-> ##20 (!tick_o || sel_i != TT_4US) ##20 (tick_o || sel_i != TT_4US);
  endproperty
  a_tt_4us: assert property (p_tt_4us) else $error("4 us period wrong");
endmodule

// *** hw/rtstc_top.sv ***
// Run enable, shutdown scope and time-tag clock control with its register port.
// How it works
// - Scope one: shutdown command mutes transmitter only.
// - Muted bus still receives; never transmits there.
// - Built-in test word shows shutdown state.
// - Clock select bits 11:9, code 0 stops.
// - Code 1 counts external time-tag clock pin.
// - Other codes give 2 to 64 us clocks.
// - Run bit 8 starts and stops terminal.
// - Address parity error blocks run despite bit.
// - Parity error sets status and pending flags.
// - Master reset clears run bit.
// - Scope zero: shutdown disables transmitter and receiver.
module rtstc_top import rtstc_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [4:0]        terminal_address_i,
  input  wire logic              terminal_address_parity_i,
  input  wire logic              shutdown_cmd_i,
  input  wire logic              override_cmd_i,
  input  wire logic              cmd_bus_i,
  input  wire logic              timetag_ext_clock_pin_i,
  output logic                   timetag_tick_o,
  output logic                   run_o,
  output logic      [1:0]        tx_enable_o,
  output logic      [1:0]        rx_enable_o,
  output logic                   irq_o
);
  typedef struct packed {
    logic              shutdown_scope_select;
    logic [2:0]        timetag_clock_select;
    logic              run_enable;
    logic              auto_shutdown_disable;
    logic [1:0]        tx_off;
    logic [1:0]        rx_off;
    logic              address_parity_fail_flag;
    logic              run_prev;
    logic              run;
    logic [1:0]        tx_en;
    logic [1:0]        rx_en;
    logic [DATA_W-1:0] rdata;
  } rtstc_state_t;

  rtstc_state_t     s_reg;
  rtstc_state_t     s_next;
  rtstc_irq_if      irq_b ();
  logic             run_rise;
  logic             parity_bad;
  logic             auto_active;
  logic             sd_evt;
  logic             apf_evt;
  logic             wr_cfg1;
  logic             wr_cfg2;
  logic [INT_W-1:0] evt_vec;

  // Decode of the register port; each write is a single strobe cycle.
  assign wr_cfg1 = wr_i && (addr_i == OFF_CONFIG_ONE);
  assign wr_cfg2 = wr_i && (addr_i == OFF_CONFIG_TWO);

  // The automatic shutdown machinery only works while the disable option is zero.
  assign auto_active = ~s_reg.auto_shutdown_disable;

  // The address with its parity bit must carry odd parity to be accepted.
  assign parity_bad = ~(^{terminal_address_i, terminal_address_parity_i});
  assign run_rise   = s_reg.run_enable & ~s_reg.run_prev;

  assign sd_evt  = shutdown_cmd_i && auto_active;
  assign apf_evt = run_rise && parity_bad;

  always_comb begin
    evt_vec               = '0;
    evt_vec[INT_APF]      = apf_evt;
    evt_vec[INT_SHUTDOWN] = sd_evt;
  end

  always_comb begin
    s_next          = s_reg;
    s_next.run_prev = s_reg.run_enable;

    // Configuration register one.
    if (wr_cfg1) begin
      s_next.shutdown_scope_select = wdata_i[SCOPE_BIT];
      s_next.timetag_clock_select  = wdata_i[TTSEL_LSB +: 3];
      s_next.run_enable            = wdata_i[RUN_BIT];
    end

    // Configuration register two holds only the shutdown option bit here.
    if (wr_cfg2) begin
      s_next.auto_shutdown_disable = wdata_i[AUTO_SD_DIS_BIT];
    end

    // The parity check is made once, on the cycle after the run bit rises,
    // and the failure stands until software drops the run bit again.
    if (!s_reg.run_enable) begin
      s_next.address_parity_fail_flag = 1'b0;
    end else if (apf_evt) begin
      s_next.address_parity_fail_flag = 1'b1;
    end

    // Terminal runs only while enabled and the address was accepted.
    s_next.run = s_reg.run_enable && !s_next.address_parity_fail_flag;

    // An override command re-enables the named bus; a shutdown in the same
    // cycle is applied after it and so wins.
    if (override_cmd_i && auto_active) begin
      s_next.tx_off[cmd_bus_i] = 1'b0;
      s_next.rx_off[cmd_bus_i] = 1'b0;
    end
    if (sd_evt) begin
      s_next.tx_off[cmd_bus_i] = 1'b1;
      if (!s_reg.shutdown_scope_select) begin
        s_next.rx_off[cmd_bus_i] = 1'b1;
      end
    end

    // With the option turned off the host governs the buses itself.
    if (!auto_active) begin
      s_next.tx_off = 2'h0;
      s_next.rx_off = 2'h0;
    end

    // A muted bus keeps its receiver, so commands on it are still taken
    // and stored, while no status or data can leave on that bus.
    s_next.tx_en = ~s_next.tx_off;
    s_next.rx_en = ~s_next.rx_off;

    // Read data stand for exactly one cycle after the strobe.
    s_next.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        OFF_CONFIG_ONE: begin
          s_next.rdata[SCOPE_BIT]          = s_reg.shutdown_scope_select;
          s_next.rdata[TTSEL_LSB +: 3]     = s_reg.timetag_clock_select;
          s_next.rdata[RUN_BIT]            = s_reg.run_enable;
        end
        OFF_CONFIG_TWO: begin
          s_next.rdata[AUTO_SD_DIS_BIT]    = s_reg.auto_shutdown_disable;
        end
        OFF_STATUS: begin
          s_next.rdata[STAT_APF_BIT]       = s_reg.address_parity_fail_flag;
          s_next.rdata[STAT_RUN_BIT]       = s_reg.run;
        end
        OFF_BIT_WORD: begin
          if (auto_active) begin
            s_next.rdata[BITW_TX_LSB +: 2] = s_reg.tx_off;
            s_next.rdata[BITW_RX_LSB +: 2] = s_reg.rx_off;
          end
        end
        OFF_INT_PEND: s_next.rdata = DATA_W'(irq_b.pending);
        OFF_INT_MASK: s_next.rdata = DATA_W'(irq_b.mask);
        default:      s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg                          <= '0;
      s_reg.shutdown_scope_select    <= SCOPE_RESET;
      s_reg.timetag_clock_select     <= TTSEL_RESET;
      s_reg.run_enable               <= RUN_RESET;
      s_reg.auto_shutdown_disable    <= AUTO_SD_DIS_RESET;
      s_reg.tx_en                    <= 2'h3;
      s_reg.rx_en                    <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  // Interrupt status block; software clears pending bits by writing ones.
  assign irq_b.event_set  = evt_vec;
  assign irq_b.clear_ones = (wr_i && addr_i == OFF_INT_PEND) ? wdata_i[INT_W-1:0] : '0;
  assign irq_b.mask_we    = wr_i && (addr_i == OFF_INT_MASK);
  assign irq_b.mask_wdata = wdata_i[INT_W-1:0];

  rtstc_irq u_irq (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .irq_b   (irq_b)
  );

  rtstc_tick_gen u_tick (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .sel_i     (s_reg.timetag_clock_select),
    .ext_clk_i (timetag_ext_clock_pin_i),
    .tick_o    (timetag_tick_o)
  );

  assign rdata_o     = s_reg.rdata;
  assign run_o       = s_reg.run;
  assign tx_enable_o = s_reg.tx_en;
  assign rx_enable_o = s_reg.rx_en;
  assign irq_o       = irq_b.irq;

  property p_mute_tx_only;
    @(posedge clk_i) disable iff (reset_i)
      (shutdown_cmd_i && auto_active && s_reg.shutdown_scope_select && !override_cmd_i)
        |=> ##1 (!tx_enable_o[$past(cmd_bus_i, 2)] && rx_enable_o == $past(rx_enable_o, 2));
  endproperty
  a_mute_tx_only: assert property (p_mute_tx_only) else $error("mute not tx only");

  property p_muted_keeps_rx;
    @(posedge clk_i) disable iff (reset_i)
      (s_reg.tx_off != 2'h0 && s_reg.rx_off == 2'h0 && !(sd_evt && !s_reg.shutdown_scope_select))
        |=> rx_enable_o == 2'h3;
  endproperty
  a_muted_keeps_rx: assert property (p_muted_keeps_rx) else $error("muted bus rx lost");

  property p_full_shutdown;
    @(posedge clk_i) disable iff (reset_i)
      (shutdown_cmd_i && auto_active && !s_reg.shutdown_scope_select)
        |=> ##1 (!tx_enable_o[$past(cmd_bus_i, 2)] && !rx_enable_o[$past(cmd_bus_i, 2)]);
  endproperty
  a_full_shutdown: assert property (p_full_shutdown) else $error("bus not shut down");

  property p_bit_word_gated;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && addr_i == OFF_BIT_WORD && !auto_active) |=> rdata_o == '0;
  endproperty
  a_bit_word_gated: assert property (p_bit_word_gated) else $error("bit word not gated");

  property p_run_follows;
    @(posedge clk_i) disable iff (reset_i)
      (wr_cfg1 && !wdata_i[RUN_BIT]) |=> ##1 !run_o;
  endproperty
  a_run_follows: assert property (p_run_follows) else $error("run did not stop");

  property p_parity_blocks;
    @(posedge clk_i) disable iff (reset_i)
      apf_evt |=> (!run_o && s_reg.run_enable) until !s_reg.run_enable;
  endproperty
  a_parity_blocks: assert property (p_parity_blocks) else $error("ran with bad parity");

  property p_parity_flags;
    @(posedge clk_i) disable iff (reset_i)
      apf_evt |=> (s_reg.address_parity_fail_flag && irq_b.pending[INT_APF]);
  endproperty
  a_parity_flags: assert property (p_parity_flags) else $error("parity flags not set");

  property p_reset_stops;
    @(posedge clk_i) reset_i |=> (!s_reg.run_enable && !run_o);
  endproperty
  a_reset_stops: assert property (p_reset_stops) else $error("reset left run set");

  // The checks below tie the register port, run control and bus enables together.
  property p_reset_buses;
    @(posedge clk_i)
      reset_i |=> (tx_enable_o == 2'h3 && rx_enable_o == 2'h3);
  endproperty
  a_reset_buses: assert property (p_reset_buses) else $error("buses off after reset");

  property p_reset_config;
    @(posedge clk_i)
      reset_i |=> (s_reg.timetag_clock_select == TTSEL_RESET && !s_reg.shutdown_scope_select);
  endproperty
  a_reset_config: assert property (p_reset_config) else $error("config not reset");

  property p_run_starts;
    @(posedge clk_i) disable iff (reset_i)
      (run_rise && !parity_bad) |=> run_o;
  endproperty
  a_run_starts: assert property (p_run_starts) else $error("run did not start");

  property p_run_needs_enable;
    @(posedge clk_i) disable iff (reset_i)
      run_o |-> $past(s_reg.run_enable);
  endproperty
  a_run_needs_enable: assert property (p_run_needs_enable) else $error("run without bit");

  property p_flag_blocks_run;
    @(posedge clk_i) disable iff (reset_i)
      s_reg.address_parity_fail_flag |=> !run_o;
  endproperty
  a_flag_blocks_run: assert property (p_flag_blocks_run) else $error("ran while flagged");

  property p_flag_needs_enable;
    @(posedge clk_i) disable iff (reset_i)
      s_reg.address_parity_fail_flag |-> $past(s_reg.run_enable);
  endproperty
  a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("stale flag");

  property p_good_parity_clean;
    @(posedge clk_i) disable iff (reset_i)
      (run_rise && !parity_bad) |=> !s_reg.address_parity_fail_flag;
  endproperty
  a_good_parity_clean: assert property (p_good_parity_clean) else $error("false flag");

  property p_cfg_write;
    @(posedge clk_i) disable iff (reset_i)
      wr_cfg1 |=> (s_reg.timetag_clock_select == $past(wdata_i[TTSEL_LSB +: 3])
                   && s_reg.run_enable == $past(wdata_i[RUN_BIT]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_scope_write;
    @(posedge clk_i) disable iff (reset_i)
      wr_cfg1 |=> s_reg.shutdown_scope_select == $past(wdata_i[SCOPE_BIT]);
  endproperty
  a_scope_write: assert property (p_scope_write) else $error("scope write lost");

  property p_cfg_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && addr_i == OFF_CONFIG_ONE)
        |=> (rdata_o[TTSEL_LSB +: 3] == $past(s_reg.timetag_clock_select)
             && rdata_o[RUN_BIT] == $past(s_reg.run_enable));
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

  property p_status_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && addr_i == OFF_STATUS)
        |=> (rdata_o[STAT_RUN_BIT] == $past(run_o)
             && rdata_o[STAT_APF_BIT] == $past(s_reg.address_parity_fail_flag));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_bit_word_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && addr_i == OFF_BIT_WORD && auto_active)
        |=> (rdata_o[BITW_TX_LSB +: 2] == ~$past(tx_enable_o)
             && rdata_o[BITW_RX_LSB +: 2] == ~$past(rx_enable_o));
  endproperty
  a_bit_word_read: assert property (p_bit_word_read) else $error("bit word wrong");

  property p_shutdown_pending;
    @(posedge clk_i) disable iff (reset_i)
      sd_evt |=> irq_b.pending[INT_SHUTDOWN];
  endproperty
  a_shutdown_pending: assert property (p_shutdown_pending) else $error("no shutdown flag");

  property p_option_off_enables;
    @(posedge clk_i) disable iff (reset_i)
      !auto_active |=> (tx_enable_o == 2'h3 && rx_enable_o == 2'h3);
  endproperty
  a_option_off_enables: assert property (p_option_off_enables) else $error("bus left off");

  property p_scope_keeps_rx;
    @(posedge clk_i) disable iff (reset_i)
      (sd_evt && s_reg.shutdown_scope_select && !override_cmd_i)
        |=> rx_enable_o == $past(rx_enable_o);
  endproperty
  a_scope_keeps_rx: assert property (p_scope_keeps_rx) else $error("receiver changed");

  property p_irq_level;
    @(posedge clk_i) disable iff (reset_i)
      irq_o == |(irq_b.pending & irq_b.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
endmodule

// *** verification/rtstc_bc_model.sv ***
// Bus controller model that issues shutdown and override mode commands.
module rtstc_bc_model (
  input  wire logic clk_i,
  output logic      shutdown_cmd_o,
  output logic      override_cmd_o,
  output logic      cmd_bus_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    shutdown_cmd_o = 1'h0;
    override_cmd_o = 1'h0;
    cmd_bus_o      = 1'h0;
  end

  // The bus select flips after the pulse, because it carries no meaning then.
  task automatic send(input logic shut, input logic bus);
    @(posedge clk_i);
    shutdown_cmd_o <= shut;
    override_cmd_o <= !shut;
    cmd_bus_o      <= bus;
    @(posedge clk_i);
    shutdown_cmd_o <= 1'h0;
    override_cmd_o <= 1'h0;
    cmd_bus_o      <= !bus;
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking testbench of the run, shutdown and time-tag control block.
module tb import rtstc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_i = 1'h0;
  logic              reset_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic [4:0]        ta;
  logic              par;
  logic              sd;
  logic              ov;
  logic              bus;
  logic              pin;
  logic              tick;
  logic              run;
  logic [1:0]        tx;
  logic [1:0]        rx;
  logic              irq;
  logic              rd_seen = 1'h0;
  logic [15:0]       exp_q[$];
  logic [3:0]        adr_q[$];
  int                err_total = 0;
  int                check_count = 0;
  int                cyc = 0;
  int                tick_cnt = 0;
  int                n;
  int                k;
  int                t0;
  logic [15:0]       r;

  rtstc_top DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .terminal_address_i(ta),
    .terminal_address_parity_i(par), .shutdown_cmd_i(sd), .override_cmd_i(ov),
    .cmd_bus_i(bus), .timetag_ext_clock_pin_i(pin), .timetag_tick_o(tick), .run_o(run),
    .tx_enable_o(tx), .rx_enable_o(rx), .irq_o(irq));

  rtstc_bc_model u_bc (.clk_i(clk_i), .shutdown_cmd_o(sd), .override_cmd_o(ov), .cmd_bus_o(bus));

  always #50 clk_i = ~clk_i;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clk_i);
    wr_i    <= 1'h0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    exp_q.push_back(exp);
    adr_q.push_back(a);
    @(posedge clk_i);
    rd_i   <= 1'h0;
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic gap(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1;
      cnt++;
    end while (tick !== 1'h1 && cnt < 1000);
  endtask

  task automatic pulse_pin(input int times);
    repeat (times) begin
      @(posedge clk_i);
      pin <= 1'h1;
      repeat (2) @(posedge clk_i);
      pin <= 1'h0;
      repeat (2) @(posedge clk_i);
    end
  endtask

  // Read data appear only in the cycle after the strobe, so they are taken there.
  always @(posedge clk_i) begin
    if (rd_seen) begin
      check($sformatf("rdata_%0h", adr_q.pop_front()), rdata_o, exp_q.pop_front());
    end
    rd_seen <= rd_i;
    tick_cnt <= tick_cnt + int'(tick);
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'hf357b78a));
    reset_i = 1'h1;
    addr_i  = 4'h0;
    wdata_i = 16'h0;
    wr_i    = 1'h0;
    rd_i    = 1'h0;
    pin     = 1'h0;
    ta      = 5'($urandom);
    par     = ~^ta;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    #1;
    check("run", {15'h0, run}, 16'h0);
    check("txrx", {12'h0, tx, rx}, 16'h000f);
    reg_rd(OFF_CONFIG_ONE, 16'h0);
    reg_rd(OFF_CONFIG_TWO, 16'h0);
    r = 16'($urandom);
    reg_wr(OFF_CONFIG_ONE, r & 16'hfeff);
    reg_rd(OFF_CONFIG_ONE, r & 16'h1e00);
    reg_wr(4'hf, 16'hffff);
    reg_rd(4'hf, 16'h0);
    reg_wr(OFF_CONFIG_ONE, 16'h0100);
    settle();
    check("run", {15'h0, run}, 16'h1);
    reg_rd(OFF_STATUS, 16'h0002);
    reset_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    #1;
    check("run_reset", {15'h0, run}, 16'h0);
    reg_rd(OFF_CONFIG_ONE, 16'h0);
    reg_wr(OFF_CONFIG_ONE, 16'h0);
    settle();
    check("run", {15'h0, run}, 16'h0);
    par <= ^ta;
    reg_wr(OFF_CONFIG_ONE, 16'h0100);
    settle();
    check("run", {15'h0, run}, 16'h0);
    reg_rd(OFF_STATUS, 16'h0001);
    reg_rd(OFF_INT_PEND, 16'h0001);
    check("irq", {15'h0, irq}, 16'h0);
    reg_wr(OFF_INT_MASK, 16'h0001);
    settle();
    check("irq", {15'h0, irq}, 16'h1);
    reg_wr(OFF_INT_PEND, 16'h0001);
    settle();
    check("irq", {15'h0, irq}, 16'h0);
    reg_rd(OFF_INT_PEND, 16'h0);
    reg_wr(OFF_CONFIG_ONE, 16'h0);
    reg_rd(OFF_STATUS, 16'h0);
    par <= ~^ta;
    u_bc.send(1'h1, 1'h1);
    settle();
    check("txrx", {12'h0, tx, rx}, 16'h0005);
    reg_rd(OFF_BIT_WORD, 16'h000a);
    reg_rd(OFF_INT_PEND, 16'h0002);
    u_bc.send(1'h0, 1'h1);
    reg_wr(OFF_CONFIG_ONE, 16'h1000);
    u_bc.send(1'h1, 1'h0);
    settle();
    check("txrx", {12'h0, tx, rx}, 16'h000b);
    reg_rd(OFF_BIT_WORD, 16'h0001);
    reg_wr(OFF_CONFIG_TWO, 16'h0010);
    u_bc.send(1'h1, 1'h1);
    settle();
    check("txrx", {12'h0, tx, rx}, 16'h000f);
    reg_rd(OFF_BIT_WORD, 16'h0);
    reg_wr(OFF_CONFIG_ONE, 16'h0);
    settle();
    t0 = tick_cnt;
    pulse_pin(3);
    repeat (40) @(posedge clk_i);
    check("ticks_off", 16'(tick_cnt - t0), 16'h0);
    reg_wr(OFF_CONFIG_ONE, {4'h0, TT_EXT, 9'h0});
    settle();
    t0 = tick_cnt;
    k = $urandom_range(8, 3);
    pulse_pin(k);
    settle();
    check("ticks_ext", 16'(tick_cnt - t0), 16'(k));
    for (int c = 2; c < 8; c++) begin
      reg_wr(OFF_CONFIG_ONE, 16'(c) << 9);
      gap(n);
      gap(n);
      check($sformatf("period_%0d", c), 16'(n), 16'(int'(TT_BASE_CYCLES) << (c - 2)));
    end
    settle();
    check("reads_left", 16'(exp_q.size()), 16'h0);
    end_sim();
  end
endmodule
